/* File: rtl/cmp_ctrl.sv */
// Comparator control, status and wake-up logic with a Wishbone register slave
module cmp_ctrl
  import cmp_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // Analog comparator cores
  input  wire logic        first_raw_result_i,
  input  wire logic        second_raw_result_i,
  output logic             first_comparator_on_o,
  output logic             second_comparator_on_o,
  output logic             first_neg_pin_sel_o,
  output logic             first_pos_pin_sel_o,
  output logic             second_neg_pin_sel_o,
  output logic [1:0]       second_pos_src_o,
  // Core status
  input  wire logic        sleep_i,
  input  wire logic        timer_clock_select_i,
  // Shared pins
  output logic             first_output_port_pin_o,
  output logic             first_output_port_pin_oe_o,
  output logic             first_output_override_o,
  output logic             second_output_port_pin_o,
  output logic             second_output_port_pin_oe_o,
  output logic             second_output_override_o,
  // Timer clock
  output logic             timer_comp_clock_o,
  output logic             timer_comp_clock_sel_o,
  // Wake-up and interrupt
  output logic             wake_flag_o,
  output logic             irq_o
);

  // =============================================================================
  // Storage
  logic [6:0]        ctrl1_ff;
  logic [6:0]        ctrl2_ff;
  logic [1:0]        result_ff;
  logic [1:0]        latched_ff;
  logic              latch_valid_ff;
  logic              wake_ff;
  logic [EV_NUM-1:0] stat_ff;
  logic [EV_NUM-1:0] en_ff;
  logic [1:0]        prev_ff;
  logic              ack_ff;
  logic [31:0]       rdata_ff;

  logic [1:0]        stable;
  logic [1:0]        shown;
  logic              req;
  logic              wr;
  logic              rd;
  logic [1:0]        change;
  logic              wake_set;
  logic [EV_NUM-1:0] events;

  cmp_sync_if #(.N(2)) sif ();

  assign sif.raw = {second_raw_result_i, first_raw_result_i};

  cmp_input_sync #(
    .N(2)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .sif   (sif)
  );

  assign stable = sif.stable;

  // Build an 8-bit control read value
  function automatic logic [7:0] ctrl_word(input logic res, input logic [6:0] c);
    ctrl_word = {res, c};
  endfunction

  // =============================================================================
  // Bus decode
  assign req = cyc_i && stb_i && !ack_ff;
  assign wr  = req && we_i && sel_i[0];
  assign rd  = req && !we_i;

  // Control registers; the result bit is not writable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl1_ff <= CTRL_RST;
      ctrl2_ff <= CTRL_RST;
    end else if (wr) begin
      if (adr_i == CMP1_SMALL_OFS || adr_i == CMP1_LARGE_OFS) begin
        ctrl1_ff <= dat_i[6:0];
      end
      if (adr_i == CMP2_CTRL_OFS) begin
        ctrl2_ff <= dat_i[6:0];
      end
    end
  end

  // =============================================================================
  // Polarity applied; an off comparator holds its last result
  assign shown[0] = ctrl1_ff[POL_BIT] ? stable[0] : ~stable[0];
  assign shown[1] = ctrl2_ff[POL_BIT] ? stable[1] : ~stable[1];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_ff <= RESULT_RST;
    end else begin
      if (ctrl1_ff[ON_BIT]) begin
        result_ff[0] <= shown[0];
      end
      if (ctrl2_ff[ON_BIT]) begin
        result_ff[1] <= shown[1];
      end
    end
  end

  // =============================================================================
  // Analog steering
  assign first_comparator_on_o  = ctrl1_ff[ON_BIT];
  assign second_comparator_on_o = ctrl2_ff[ON_BIT];
  assign first_neg_pin_sel_o    = ctrl1_ff[NEG_BIT];
  assign first_pos_pin_sel_o    = ctrl1_ff[POS_BIT];
  assign second_neg_pin_sel_o   = ctrl2_ff[NEG_BIT];
  // 2: own positive pin, 1: first positive pin, 0: second negative pin
  always_comb begin
    if (ctrl2_ff[POS_BIT]) begin
      second_pos_src_o = 2'h2;
    end else if (ctrl2_ff[TSRC_BIT]) begin
      second_pos_src_o = 2'h1;
    end else begin
      second_pos_src_o = 2'h0;
    end
  end

  // =============================================================================
  // Output pins; overrides act only while the comparator is on
  assign first_output_override_o    = ctrl1_ff[ON_BIT] && !ctrl1_ff[PIN_DIS_BIT];
  assign first_output_port_pin_oe_o = first_output_override_o;
  assign first_output_port_pin_o    = result_ff[0];
  assign second_output_override_o    = ctrl2_ff[ON_BIT] && !ctrl2_ff[PIN_DIS_BIT];
  assign second_output_port_pin_oe_o = second_output_override_o;
  assign second_output_port_pin_o    = result_ff[1];

  // Timer clock from comparator 1 when its source bit is clear
  assign timer_comp_clock_sel_o = ctrl1_ff[ON_BIT] && timer_clock_select_i
                                  && !ctrl1_ff[TSRC_BIT];
  assign timer_comp_clock_o     = result_ff[0];

  // =============================================================================
  // Latch last known state on a control register read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latched_ff     <= RESULT_RST;
      latch_valid_ff <= 1'b0;
    end else if (rd && (adr_i == CMP1_SMALL_OFS || adr_i == CMP1_LARGE_OFS
                        || adr_i == CMP2_CTRL_OFS)) begin
      latched_ff     <= result_ff;
      latch_valid_ff <= 1'b1;
    end
  end

  assign change[0] = ctrl1_ff[ON_BIT] && !ctrl1_ff[WAKE_DIS_BIT]
                     && (result_ff[0] != latched_ff[0]);
  assign change[1] = ctrl2_ff[ON_BIT] && !ctrl2_ff[WAKE_DIS_BIT]
                     && (result_ff[1] != latched_ff[1]);
  assign wake_set  = sleep_i && latch_valid_ff && (|change);

  // Wake flag: set wins over a software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_ff <= 1'b0;
    end else if (wake_set) begin
      wake_ff <= 1'b1;
    end else if (wr && adr_i == MISC_OFS && dat_i[MISC_WUF_BIT]) begin
      wake_ff <= 1'b0;
    end
  end

  assign wake_flag_o = wake_ff;

  // =============================================================================
  // Interrupt status: wake and result edges
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_ff <= RESULT_RST;
    end else begin
      prev_ff <= result_ff;
    end
  end

  assign events = {prev_ff[1] != result_ff[1], prev_ff[0] != result_ff[0], wake_set};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_ff <= '0;
    end else if (wr && adr_i == IRQ_CLR_OFS) begin
      stat_ff <= (stat_ff & ~dat_i[EV_NUM-1:0]) | events;
    end else begin
      stat_ff <= stat_ff | events;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_ff <= '0;
    end else if (wr && adr_i == IRQ_EN_OFS) begin
      en_ff <= dat_i[EV_NUM-1:0];
    end
  end

  assign irq_o = |(stat_ff & en_ff);

  // =============================================================================
  // Read data and acknowledge, one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff   <= 1'b0;
      rdata_ff <= '0;
    end else begin
      ack_ff <= req;
      if (rd) begin
        case (adr_i)
          CMP1_SMALL_OFS: rdata_ff <= {24'h0, ctrl_word(result_ff[0], ctrl1_ff)};
          CMP1_LARGE_OFS: rdata_ff <= {24'h0, ctrl_word(result_ff[0], ctrl1_ff)};
          CMP2_CTRL_OFS:  rdata_ff <= {24'h0, ctrl_word(result_ff[1], ctrl2_ff)};
          IRQ_STAT_OFS:   rdata_ff <= {29'h0, stat_ff};
          IRQ_EN_OFS:     rdata_ff <= {29'h0, en_ff};
          MISC_OFS:       rdata_ff <= {29'h0, wake_ff, sleep_i, timer_clock_select_i};
          default:        rdata_ff <= '0;
        endcase
      end
    end
  end

  assign ack_o = ack_ff;
  assign dat_o = rdata_ff;

endmodule

/* File: common/cmp_ctrl_pkg.sv */
// Package with register map, field positions and reset values of the comparator control block
// =============================================================================
package cmp_ctrl_pkg;

  // =============================================================================
  // Register word offsets (byte addresses)
  localparam logic [7:0] CMP1_SMALL_OFS = 8'h00;
  localparam logic [7:0] CMP1_LARGE_OFS = 8'h04;
  localparam logic [7:0] CMP2_CTRL_OFS  = 8'h08;
  localparam logic [7:0] IRQ_STAT_OFS   = 8'h0c;
  localparam logic [7:0] IRQ_EN_OFS     = 8'h10;
  localparam logic [7:0] IRQ_CLR_OFS    = 8'h14;
  localparam logic [7:0] MISC_OFS       = 8'h18;

  // =============================================================================
  // Field positions within a control register
  localparam int RESULT_BIT  = 7;
  localparam int PIN_DIS_BIT = 6;
  localparam int POL_BIT     = 5;
  localparam int TSRC_BIT    = 4; // Comparator 2: alternate positive select
  localparam int ON_BIT      = 3;
  localparam int NEG_BIT     = 2;
  localparam int POS_BIT     = 1;
  localparam int WAKE_DIS_BIT = 0;

  // Fields of the miscellaneous register
  localparam int MISC_TCS_BIT   = 0; // Timer clock select mirror
  localparam int MISC_SLEEP_BIT = 1; // Read only sleep state
  localparam int MISC_WUF_BIT   = 2; // Wake-up flag, write one clears

  // Status bits
  localparam int EV_WAKE = 0;
  localparam int EV_C1   = 1;
  localparam int EV_C2   = 2;
  localparam int EV_NUM  = 3;

  // =============================================================================
  // Reset values
  localparam logic [6:0] CTRL_RST = 7'h7f;
  localparam logic [1:0] RESULT_RST = 2'h3;
  localparam logic       TCS_RST  = 1'h1;

  // Synchroniser depth
  localparam int SYNC_STAGES = 3;

endpackage

/* File: common/cmp_sync_if.sv */
// Interface carrying raw and synchronised comparator outputs
interface cmp_sync_if #(
  parameter int N = 2
);
  logic [N-1:0] raw;
  logic [N-1:0] stable;
  modport src  (input stable, output raw);
  modport sync (input raw, output stable);
endinterface

/* File: rtl/cmp_input_sync.sv */
// Three-stage synchroniser with agreement filter for comparator outputs
module cmp_input_sync
  import cmp_ctrl_pkg::*;
#(
  parameter int N = 2
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Signals
  cmp_sync_if.sync  sif
);

  logic [N-1:0] s1_ff;
  logic [N-1:0] s2_ff;
  logic [N-1:0] s3_ff;
  logic [N-1:0] stable_ff;

  // Shift chain; first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_ff <= '1;
      s2_ff <= '1;
      s3_ff <= '1;
    end else begin
      s1_ff <= sif.raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Accept a change once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_agree
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          stable_ff[g] <= 1'b1;
        end else if (s2_ff[g] == s3_ff[g]) begin
          stable_ff[g] <= s3_ff[g];
        end
      end
    end
  endgenerate

  assign sif.stable = stable_ff;

endmodule

/* File: verification/cmp_core_model.sv */
// Behavioural model of the two analog comparator cores
module cmp_core_model #(
  parameter int SETTLE = 4
) (
  input  wire logic       clk_i,
  input  wire logic [1:0] gt_i,
  input  wire logic [1:0] on_i,
  input  wire logic [4:0] src_i,
  output logic      [1:0] raw_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] src_ff = 5'h00;
  int         wait_ff [2] = '{0, 0};
  initial raw_o = 2'h0;
  // =============================================================================
  // Output is garbage while off and until settled after any change of the source selects
  always @(posedge clk_i) begin
    src_ff <= src_i;
    for (int k = 0; k < 2; k++) begin
      if (!on_i[k] || src_i != src_ff) wait_ff[k] <= SETTLE;
      else if (wait_ff[k] > 0) wait_ff[k] <= wait_ff[k] - 1;
      raw_o[k] <= (wait_ff[k] == 0) ? gt_i[k] : ~raw_o[k];
    end
  end
endmodule

/* File: verification/cmp_ctrl_chk.sv */
// Checker of bus and pin relations of the comparator control block
module cmp_ctrl_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic first_comparator_on_o,
  input wire logic second_comparator_on_o,
  input wire logic sleep_i,
  input wire logic timer_clock_select_i,
  input wire logic first_output_port_pin_o,
  input wire logic first_output_port_pin_oe_o,
  input wire logic first_output_override_o,
  input wire logic second_output_port_pin_o,
  input wire logic second_output_port_pin_oe_o,
  input wire logic timer_comp_clock_o,
  input wire logic timer_comp_clock_sel_o,
  input wire logic wake_flag_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // =============================================================================
  // Steps of a bus cycle and of an idle comparator
  sequence take_s;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence off2_s;
    !second_comparator_on_o [*3];
  endsequence
  ack_once_a: assert property (take_s |=> ack_o ##1 !ack_o)
    else $error("ack not a single pulse after request");
  ack_cause_a: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  oe1_on_a: assert property (first_output_port_pin_oe_o |-> first_comparator_on_o)
    else $error("first pin driven while off");
  oe2_on_a: assert property (second_output_port_pin_oe_o |-> second_comparator_on_o)
    else $error("second pin driven while off");
  override_a: assert property (first_output_override_o == first_output_port_pin_oe_o)
    else $error("direction override differs from pin drive");
  tsel_on_a: assert property (timer_comp_clock_sel_o |-> first_comparator_on_o && timer_clock_select_i)
    else $error("timer source without its conditions");
  tclk_on_a: assert property ($changed(timer_comp_clock_o) |-> $past(first_comparator_on_o))
    else $error("timer clock moved while comparator 1 off");
  wake_sleep_a: assert property ($rose(wake_flag_o) |-> $past(sleep_i))
    else $error("wake flag set while awake");
  hold_off_a: assert property (off2_s |-> $stable(second_output_port_pin_o))
    else $error("result moved while off");
endmodule

bind cmp_ctrl cmp_ctrl_chk cmp_ctrl_chk_inst (.*);

/* File: verification/tb_top.sv */
// Self-checking testbench of the comparator control block
module tb_top
  import cmp_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic sleep_i = 0, timer_clock_select_i = 0, ack_o, r1, r2;
  logic [7:0] adr_i = 8'h00, c1, c2;
  logic [3:0] sel_i = 4'h1;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic [1:0] gt = 2'h0, second_pos_src_o;
  logic first_comparator_on_o, second_comparator_on_o, first_neg_pin_sel_o;
  logic first_pos_pin_sel_o, second_neg_pin_sel_o, first_output_port_pin_o;
  logic first_output_port_pin_oe_o, first_output_override_o, second_output_port_pin_o;
  logic second_output_port_pin_oe_o, second_output_override_o, timer_comp_clock_o;
  logic timer_comp_clock_sel_o, wake_flag_o, irq_o;
  wire  first_raw_result_i, second_raw_result_i;
  int   num_errors = 0, checks_done = 0, seed = 43300;
  always #4 clk_i = ~clk_i;
  cmp_ctrl cmp_ctrl_inst (.*);
  cmp_core_model cmp_core_model_inst (.clk_i(clk_i), .gt_i(gt),
    .on_i({second_comparator_on_o, first_comparator_on_o}),
    .src_i({first_neg_pin_sel_o, first_pos_pin_sel_o, second_neg_pin_sel_o, second_pos_src_o}),
    .raw_o({second_raw_result_i, first_raw_result_i}));
  // =============================================================================
  // Compare, bus cycle and verdict
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    // Hold the request until ack is seen high at a rising edge; the watchdog ends a hang
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  function automatic logic [1:0] pos2(input logic [7:0] c);
    return c[1] ? 2'h2 : (c[4] ? 2'h1 : 2'h0);
  endfunction
  task automatic results();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Cut a hang short
  initial begin
    #200000;
    num_errors++;
    results();
  end
  // =============================================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, CMP1_SMALL_OFS, 0);
    chk("ctrl1 reset", 32'hff, rd);
    wb(0, CMP2_CTRL_OFS, 0);
    chk("ctrl2 reset", 32'hff, rd);
    wb(0, 8'h1c, 0);
    chk("unmapped", 32'h0, rd);
    $display("reset test done");
    for (int i = 0; i < 24; i++) begin
      c1 = 8'($random(seed)) | 8'h08;
      c2 = 8'($random(seed));
      gt <= 2'($random(seed));
      timer_clock_select_i <= 1'($random(seed));
      wb(1, CMP1_LARGE_OFS, {24'h0, c1});
      wb(1, CMP2_CTRL_OFS, {24'h0, c2});
      repeat (16) @(posedge clk_i);
      r1 = c1[5] ? gt[0] : ~gt[0];
      r2 = c2[5] ? gt[1] : ~gt[1];
      wb(0, CMP1_SMALL_OFS, 0);
      chk("ctrl1", {24'h0, r1, c1[6:0]}, rd);
      chk("pin1", r1, first_output_port_pin_o);
      chk("oe1", !c1[6], first_output_port_pin_oe_o);
      chk("ovr1", !c1[6], first_output_override_o);
      chk("tclk", r1, timer_comp_clock_o);
      chk("sel1", {c1[2], c1[1]}, {first_neg_pin_sel_o, first_pos_pin_sel_o});
      chk("tsel", timer_clock_select_i & ~c1[4], timer_comp_clock_sel_o);
      chk("on2", c2[3], second_comparator_on_o);
      chk("oe2", c2[3] & ~c2[6], second_output_port_pin_oe_o);
      chk("ovr2", c2[3] & ~c2[6], second_output_override_o);
      if (c2[3]) begin
        chk("sel2", {c2[2], pos2(c2)}, {second_neg_pin_sel_o, second_pos_src_o});
        chk("pin2", r2, second_output_port_pin_o);
        wb(0, CMP2_CTRL_OFS, 0);
        chk("ctrl2", {24'h0, r2, c2[6:0]}, rd);
      end
    end
    sel_i <= 4'h0;
    wb(1, CMP1_SMALL_OFS, 0);
    sel_i <= 4'h1;
    wb(0, CMP1_SMALL_OFS, 0);
    chk("masked write", {24'h0, r1, c1[6:0]}, rd);
    $display("control test done");
    // Wake disabled, then enabled, each with a change during sleep
    for (int w = 0; w < 2; w++) begin
      wb(1, CMP1_SMALL_OFS, {31'h14, ~w[0]});
      wb(1, CMP2_CTRL_OFS, 32'h01);
      wb(1, IRQ_EN_OFS, 32'h7);
      repeat (16) @(posedge clk_i);
      wb(1, IRQ_CLR_OFS, 32'h7);
      wb(0, CMP1_SMALL_OFS, 0);
      sleep_i <= 1'b1;
      gt <= ~gt;
      repeat (16) @(posedge clk_i);
      chk("wake flag", w, wake_flag_o);
      wb(0, IRQ_STAT_OFS, 0);
      chk("status", {30'h0, 1'b1, w[0]}, rd);
      chk("irq", 1'b1, irq_o);
      wb(1, IRQ_EN_OFS, 32'h0);
      chk("irq masked", 1'b0, irq_o);
      // Leave sleep first, or a pending change would set the flag again
      sleep_i <= 1'b0;
      wb(1, MISC_OFS, 32'h4);
      wb(1, IRQ_CLR_OFS, 32'h7);
      chk("wake cleared", 1'b0, wake_flag_o);
    end
    $display("wake test done");
    results();
  end
endmodule
